// File: logic/magnet_menu.sv
// magnet switch filter and program-mode menu controller
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps

module switch_filter #(
	parameter int unsigned DB = menu_pkg::DB_CYC
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic raw_i,
	output logic      clean_o
);
	logic        s1_reg;
	logic        s2_reg;
	logic [31:0] cnt_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
		end else begin
			s1_reg <= raw_i;
			s2_reg <= s1_reg;
		end
	end

	// level must hold for the debounce time before it is accepted
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= 32'h0;
			clean_o <= 1'b0;
		end else if (s2_reg == clean_o) begin
			cnt_reg <= 32'h0;
		end else if (cnt_reg >= DB - 1) begin
			cnt_reg <= 32'h0;
			clean_o <= s2_reg;
		end else begin
			cnt_reg <= cnt_reg + 32'h1;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
module magnet_menu #(
	parameter int unsigned DEB_CYC = menu_pkg::DB_CYC,
	parameter int unsigned HLD_CYC = menu_pkg::HOLD_CYC,
	parameter int unsigned RST_CYC = menu_pkg::RESTORE_CYC,
	parameter int unsigned TMO_CYC = menu_pkg::TIMEOUT_CYC,
	parameter int unsigned BMP_CYC = menu_pkg::BUMP_CYC
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// magnet switches and sensor side
	input  wire logic         backward_magnet_switch_i,
	input  wire logic         forward_magnet_switch_i,
	input  wire logic         fault_i,
	input  wire logic [15:0]  gas_reading_i,
	// scrolling display
	input  wire logic         scroll_done_i,
	output menu_pkg::disp_t   disp_o,
	// mode and configuration
	output logic              program_mode_o,
	output logic              bump_active_o,
	output logic              defaults_load_o,
	output menu_pkg::cfg_t    cfg_o,
	output logic [15:0]       reading_o,
	// wishbone slave
	input  wire logic         cyc_i,
	input  wire logic         stb_i,
	input  wire logic         we_i,
	input  wire logic [3:0]   adr_i,
	input  wire logic [3:0]   sel_i,
	input  wire logic [31:0]  dat_i,
	output logic [31:0]       dat_o,
	output logic              ack_o
);
	import menu_pkg::*;

	logic        fwd;
	logic        back;
	logic        any;
	logic        any_reg;
	logic        dir_reg;
	logic        armed_reg;
	logic        arrow_reg;
	logic        used_reg;
	logic        bump_ph_reg;
	logic [31:0] hold_reg;
	logic [31:0] arrow_cnt_reg;
	logic [31:0] tmr_reg;
	state_t      state_reg;
	state_t      last_reg;
	item_t       item_reg;
	logic [3:0]  stat_idx_reg;
	logic [6:0]  edit_reg;
	logic        st_chg;
	logic        release_ev;
	logic        swipe;
	logic        long_hit;
	logic        enter_hit;
	logic        restore_hit;
	logic        step_ev;
	logic        bus_wr;
	logic [6:0]  span_wr;

	////////////////////////////////////////////////////////////////////////////
	// switch conditioning and hold timing

	switch_filter #(.DB(DEB_CYC)) u_back (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.raw_i  (backward_magnet_switch_i),
		.clean_o(back)
	);

	switch_filter #(.DB(DEB_CYC)) u_fwd (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.raw_i  (forward_magnet_switch_i),
		.clean_o(fwd)
	);

	assign any        = fwd | back;
	assign st_chg     = state_reg != last_reg;
	assign release_ev = any_reg & ~any & armed_reg;
	assign swipe      = release_ev & (hold_reg < HLD_CYC);
	assign long_hit   = armed_reg & any & (hold_reg == HLD_CYC);
	assign enter_hit  = armed_reg & arrow_reg & any & (arrow_cnt_reg == HLD_CYC) & (item_reg != IT_RESTORE);
	assign restore_hit = armed_reg & fwd & ~back & dir_reg & (item_reg == IT_RESTORE)
		& (hold_reg == RST_CYC);
	assign step_ev    = release_ev & arrow_reg & ~used_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			any_reg  <= 1'b0;
			last_reg <= ST_NORMAL;
			dir_reg  <= 1'b0;
		end else begin
			any_reg  <= any;
			last_reg <= state_reg;
			if (any & ~any_reg) begin
				dir_reg <= fwd;
			end
		end
	end

	// a press that spans a state change is ignored until release
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			armed_reg <= 1'b0;
		end else if (!any) begin
			armed_reg <= 1'b1;
		end else if (st_chg) begin
			armed_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !any || st_chg) begin
			hold_reg <= 32'h0;
		end else if (hold_reg != 32'hFFFF_FFFF) begin
			hold_reg <= hold_reg + 32'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !any || st_chg || state_reg != ST_ITEM) begin
			arrow_reg     <= 1'b0;
			arrow_cnt_reg <= 32'h0;
		end else begin
			if (scroll_done_i && armed_reg) begin
				arrow_reg <= 1'b1;
			end
			if (arrow_reg && arrow_cnt_reg != 32'hFFFF_FFFF) begin
				arrow_cnt_reg <= arrow_cnt_reg + 32'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || (any & ~any_reg)) begin
			used_reg <= 1'b0;
		end else if (enter_hit) begin
			used_reg <= 1'b1;
		end
	end

	// idle timeout in item text, run time in bump test
	always_ff @(posedge clk_i) begin
		if (rst_i || st_chg || (state_reg == ST_ITEM && any)) begin
			tmr_reg <= 32'h0;
		end else if (tmr_reg != 32'hFFFF_FFFF) begin
			tmr_reg <= tmr_reg + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// menu state machine

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg    <= ST_NORMAL;
			item_reg     <= IT_STATUS;
			stat_idx_reg <= 4'h0;
			edit_reg     <= 7'h00;
			bump_ph_reg  <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_NORMAL: begin
					if (fwd && !back) begin
						state_reg <= fault_i ? ST_FAULTS : ST_PROMPT;
					end
				end
				ST_FAULTS: begin
					if (!fwd) begin
						state_reg <= ST_NORMAL;
					end else if (scroll_done_i) begin
						state_reg <= ST_PROMPT;
					end
				end
				ST_PROMPT: begin
					if (!fwd) begin
						state_reg <= ST_NORMAL;
					end else if (hold_reg == HLD_CYC) begin
						state_reg <= ST_ITEM;
						item_reg  <= IT_STATUS;
					end
				end
				ST_ITEM: begin
					if (restore_hit) begin
						state_reg <= ST_RESTORED;
					end else if (enter_hit) begin
						unique case (item_reg)
							IT_STATUS: begin
								state_reg    <= ST_STATUS;
								stat_idx_reg <= 4'h0;
							end
							IT_GAS_TYPE: begin
								state_reg <= ST_TYPE_EDIT;
								edit_reg  <= {6'h00, cfg_o.gas_type};
							end
							IT_SPAN: begin
								state_reg <= ST_SPAN_EDIT;
								edit_reg  <= cfg_o.span;
							end
							IT_BUMP: begin
								state_reg   <= ST_BUMP;
								bump_ph_reg <= 1'b0;
							end
							default: begin
							end
						endcase
					end else if (step_ev) begin
						if (dir_reg) begin
							item_reg <= (item_reg == IT_BUS_ADDR) ? IT_STATUS : item_t'(item_reg + 4'h1);
						end else begin
							item_reg <= (item_reg == IT_STATUS) ? IT_BUS_ADDR : item_t'(item_reg - 4'h1);
						end
					end else if (tmr_reg == TMO_CYC) begin
						state_reg <= ST_NORMAL;
					end
				end
				ST_STATUS: begin
					if (scroll_done_i) begin
						if (stat_idx_reg == STATUS_LAST) begin
							state_reg <= ST_ITEM;
						end else begin
							stat_idx_reg <= stat_idx_reg + 4'h1;
						end
					end
				end
				ST_TYPE_EDIT: begin
					if (long_hit) begin
						state_reg <= ST_TYPE_SAVED;
					end else if (swipe) begin
						edit_reg[0] <= ~edit_reg[0];
					end
				end
				ST_TYPE_SAVED: begin
					if (scroll_done_i) begin
						state_reg <= ST_RANGE;
						edit_reg  <= {4'h0, cfg_o.range};
					end
				end
				ST_RANGE: begin
					if (long_hit && dir_reg && !back) begin
						state_reg <= ST_ITEM;
					end else if (swipe) begin
						edit_reg <= {4'h0, edit_reg[RANGE_W-1:0] + 3'h1};
					end
				end
				ST_SPAN_EDIT: begin
					if (long_hit && dir_reg && !back) begin
						state_reg <= ST_SPAN_SAVED;
					end else if (swipe && dir_reg && edit_reg < SPAN_MAX) begin
						edit_reg <= edit_reg + 7'h01;
					end else if (swipe && !dir_reg && edit_reg > SPAN_MIN) begin
						edit_reg <= edit_reg - 7'h01;
					end
				end
				ST_BUMP: begin
					if (swipe || tmr_reg == BMP_CYC) begin
						state_reg <= ST_BUMP_END;
					end else if (scroll_done_i) begin
						bump_ph_reg <= ~bump_ph_reg;
					end
				end
				ST_SPAN_SAVED, ST_BUMP_END, ST_RESTORED: begin
					if (scroll_done_i) begin
						state_reg <= ST_ITEM;
					end
				end
				default: begin
					state_reg <= ST_NORMAL;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// stored configuration

	assign bus_wr  = cyc_i & stb_i & we_i & ack_o & (adr_i == ADR_CONFIG);
	assign span_wr = (dat_i[CFG_SPAN_LO +: 7] < SPAN_MIN) ? SPAN_MIN :
		(dat_i[CFG_SPAN_LO +: 7] > SPAN_MAX) ? SPAN_MAX : dat_i[CFG_SPAN_LO +: 7];

	// restore beats a menu save, a menu save beats a bus write
	always_ff @(posedge clk_i) begin
		if (rst_i || state_reg == ST_RESTORED && last_reg != ST_RESTORED) begin
			cfg_o.gas_type <= GAS_TYPE_DEFAULT;
			cfg_o.range    <= RANGE_DEFAULT;
			cfg_o.span     <= SPAN_DEFAULT;
		end else if (state_reg == ST_TYPE_EDIT && long_hit) begin
			cfg_o.gas_type <= gas_type_t'(edit_reg[0]);
		end else if (state_reg == ST_RANGE && long_hit && dir_reg && !back) begin
			cfg_o.range <= edit_reg[RANGE_W-1:0];
		end else if (state_reg == ST_SPAN_EDIT && long_hit && dir_reg && !back) begin
			cfg_o.span <= edit_reg;
		end else if (bus_wr) begin
			if (sel_i[0]) begin
				cfg_o.gas_type <= gas_type_t'(dat_i[CFG_TYPE_BIT]);
				cfg_o.range    <= dat_i[CFG_RANGE_LO +: RANGE_W];
			end
			if (sel_i[1]) begin
				cfg_o.span <= span_wr;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			defaults_load_o <= 1'b0;
		end else begin
			defaults_load_o <= restore_hit && state_reg == ST_ITEM;
		end
	end

	// serial reading follows the sensor whatever the display does
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reading_o <= 16'h0000;
		end else begin
			reading_o <= gas_reading_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// display and mode outputs

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			disp_o         <= '{1'b0, 1'b0, MSG_NONE, 8'h00};
			program_mode_o <= 1'b0;
			bump_active_o  <= 1'b0;
		end else begin
			program_mode_o  <= !(state_reg inside {ST_NORMAL, ST_FAULTS, ST_PROMPT});
			bump_active_o   <= state_reg == ST_BUMP;
			disp_o.arrow_fwd  <= arrow_reg & dir_reg;
			disp_o.arrow_back <= arrow_reg & ~dir_reg;
			disp_o.value      <= 8'h00;
			unique case (state_reg)
				ST_NORMAL:     disp_o.msg <= MSG_NONE;
				ST_FAULTS:     disp_o.msg <= MSG_FAULT;
				ST_PROMPT:     disp_o.msg <= MSG_PROMPT;
				ST_ITEM: begin
					disp_o.msg   <= MSG_ITEM;
					disp_o.value <= {4'h0, item_reg};
				end
				ST_STATUS: begin
					disp_o.msg   <= MSG_STATUS;
					disp_o.value <= {4'h0, stat_idx_reg};
				end
				ST_TYPE_EDIT, ST_RANGE, ST_SPAN_EDIT: begin
					disp_o.msg   <= (state_reg == ST_TYPE_EDIT) ? MSG_TYPE_EDIT :
						(state_reg == ST_RANGE) ? MSG_RANGE_EDIT : MSG_SPAN_EDIT;
					disp_o.value <= {1'b0, edit_reg};
				end
				ST_TYPE_SAVED: disp_o.msg <= MSG_TYPE_SAVED;
				ST_SPAN_SAVED: disp_o.msg <= MSG_SPAN_SAVED;
				ST_BUMP: begin
					disp_o.msg   <= bump_ph_reg ? MSG_BUMP : MSG_LIVE;
					disp_o.value <= gas_reading_i[7:0];
				end
				ST_BUMP_END:   disp_o.msg <= MSG_BUMP_END;
				ST_RESTORED:   disp_o.msg <= MSG_RESTORED;
				default:       disp_o.msg <= MSG_NONE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// wishbone slave, one wait state, unmapped reads return zero

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= cyc_i & stb_i & ~ack_o;
			dat_o <= 32'h0000_0000;
			if (cyc_i && stb_i && !ack_o) begin
				unique case (adr_i)
					ADR_STATUS: begin
						dat_o[STA_PROG_BIT]     <= program_mode_o;
						dat_o[STA_BUMP_BIT]     <= bump_active_o;
						dat_o[STA_ITEM_LO +: 4] <= item_reg;
					end
					ADR_CONFIG: begin
						dat_o[CFG_TYPE_BIT]           <= cfg_o.gas_type;
						dat_o[CFG_RANGE_LO +: RANGE_W] <= cfg_o.range;
						dat_o[CFG_SPAN_LO +: 7]       <= cfg_o.span;
					end
					ADR_READING: dat_o[15:0] <= reading_o;
					default: dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

// File: logic/menu_pkg.sv
// constants, types and register map of the magnet menu controller
package menu_pkg;
	// timing
	localparam int unsigned CLK_HZ      = 10_000_000;
	localparam int unsigned HOLD_S      = 3;
	localparam int unsigned RESTORE_S   = 10;
	localparam int unsigned TIMEOUT_S   = 15;
	localparam int unsigned BUMP_MIN    = 2;
	localparam int unsigned DEBOUNCE_MS = 20;
	localparam int unsigned HOLD_CYC    = HOLD_S * CLK_HZ;
	localparam int unsigned RESTORE_CYC = RESTORE_S * CLK_HZ;
	localparam int unsigned TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
	localparam int unsigned BUMP_CYC    = BUMP_MIN * 60 * CLK_HZ;
	localparam int unsigned DB_CYC      = DEBOUNCE_MS * (CLK_HZ / 1000);

	// register map, byte addresses
	localparam logic [3:0] ADR_STATUS  = 4'h0;
	localparam logic [3:0] ADR_CONFIG  = 4'h4;
	localparam logic [3:0] ADR_READING = 4'h8;
	// config field positions
	localparam int CFG_TYPE_BIT = 0;
	localparam int CFG_RANGE_LO = 1;
	localparam int CFG_SPAN_LO  = 8;
	// status field positions
	localparam int STA_PROG_BIT = 0;
	localparam int STA_BUMP_BIT = 1;
	localparam int STA_ITEM_LO  = 2;

	// setting limits and factory values
	localparam int       RANGE_W       = 3;
	localparam logic [6:0] SPAN_MIN     = 7'h05;
	localparam logic [6:0] SPAN_MAX     = 7'h5F;
	localparam logic [6:0] SPAN_DEFAULT = 7'h32;
	localparam logic [RANGE_W-1:0] RANGE_DEFAULT = 3'h0;
	localparam logic [3:0] NUM_ITEMS    = 4'h9;
	localparam logic [3:0] STATUS_LAST  = 4'hF;

	typedef enum logic {GAS_EXPLOSIVE_LIMIT = 1'b0, GAS_VOLUME_FRACTION = 1'b1} gas_type_t;
	localparam gas_type_t GAS_TYPE_DEFAULT = GAS_EXPLOSIVE_LIMIT;

	typedef enum logic [3:0] {
		IT_STATUS  = 4'h0, IT_GAS_TYPE = 4'h1, IT_SPAN  = 4'h2,
		IT_FACTOR  = 4'h3, IT_BUMP     = 4'h4, IT_RESTORE = 4'h5,
		IT_RADIO   = 4'h6, IT_ALARM    = 4'h7, IT_BUS_ADDR = 4'h8
	} item_t;

	typedef enum logic [3:0] {
		MSG_NONE = 4'h0, MSG_FAULT = 4'h1, MSG_PROMPT = 4'h2, MSG_ITEM = 4'h3,
		MSG_STATUS = 4'h4, MSG_TYPE_EDIT = 4'h5, MSG_TYPE_SAVED = 4'h6,
		MSG_RANGE_EDIT = 4'h7, MSG_SPAN_EDIT = 4'h8, MSG_SPAN_SAVED = 4'h9,
		MSG_LIVE = 4'hA, MSG_BUMP = 4'hB, MSG_BUMP_END = 4'hC, MSG_RESTORED = 4'hD
	} msg_t;

	typedef enum logic [12:0] {
		ST_NORMAL     = 13'h0001, ST_FAULTS   = 13'h0002, ST_PROMPT    = 13'h0004,
		ST_ITEM       = 13'h0008, ST_STATUS   = 13'h0010, ST_TYPE_EDIT = 13'h0020,
		ST_TYPE_SAVED = 13'h0040, ST_RANGE    = 13'h0080, ST_SPAN_EDIT = 13'h0100,
		ST_SPAN_SAVED = 13'h0200, ST_BUMP     = 13'h0400, ST_BUMP_END  = 13'h0800,
		ST_RESTORED   = 13'h1000
	} state_t;

	typedef struct packed {
		logic       arrow_fwd;
		logic       arrow_back;
		msg_t       msg;
		logic [7:0] value;
	} disp_t;

	typedef struct packed {
		gas_type_t          gas_type;
		logic [RANGE_W-1:0] range;
		logic [6:0]         span;
	} cfg_t;
endpackage

// File: test/magnet_menu_bench.sv
// self-checking bench for the magnet menu controller
`timescale 1ns/1ps
module magnet_menu_bench;
	import menu_pkg::*;
	localparam int unsigned DEB  = 4;
	localparam int unsigned HLD  = 20;
	localparam int unsigned RST  = 60;
	localparam int unsigned TMO  = 100;
	localparam int unsigned BMP  = 200;
	localparam int          OPEN = HLD + 6;
	localparam int          LONG = HLD + DEB + 28;
	localparam logic [31:0] CFG_DEF = {17'h0, SPAN_DEFAULT, 4'h0, RANGE_DEFAULT, GAS_TYPE_DEFAULT};

	logic        clk_i, rst_i, back, fwd, fault, scroll, cyc, stb, we, ack, prog, bump;
	logic [15:0] gas, reading;
	logic [3:0]  scnt, adr, sel;
	logic [31:0] wdat, rdat, rd;
	disp_t       disp;
	cfg_t        cfg;
	int          miscompares, cmp_count, cycles;

	magnet_menu #(.DEB_CYC(DEB), .HLD_CYC(HLD), .RST_CYC(RST), .TMO_CYC(TMO), .BMP_CYC(BMP)) i_magnet_menu (
		.clk_i(clk_i), .rst_i(rst_i), .backward_magnet_switch_i(back), .forward_magnet_switch_i(fwd),
		.fault_i(fault), .gas_reading_i(gas), .scroll_done_i(scroll), .disp_o(disp), .program_mode_o(prog),
		.bump_active_o(bump), .defaults_load_o(), .cfg_o(cfg), .reading_o(reading), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack)
	);
	// settle covers the debounce lag, the menu step and the display register behind it
	magnet_operator #(.SETTLE(DEB + 6)) i_magnet_operator (.clk_i(clk_i), .disp_i(disp), .back_o(back), .fwd_o(fwd));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// display scroll pulses and run limit
	always @(posedge clk_i) begin
		scnt <= scnt + 4'h1;
		scroll <= (scnt == 4'hF);
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			test_done();
		end
	end

	task automatic test_done();
		$display("counts: %0d mismatches in %0d comparisons", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// waits for ack as long as it takes; only the run limit ends a stuck wait
	task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic cfg_is(input logic [31:0] exp);
		wb(1'b0, ADR_CONFIG, 4'hF, 32'h0);
		check(rd, exp, "config");
	endtask

	task automatic item_is(input item_t k);
		check({20'h0, disp.msg, disp.value}, {20'h0, MSG_ITEM, 4'h0, k}, "item");
	endtask

	initial begin
		rst_i = 1'b1;
		fault = 1'b0;
		gas = 16'h0000;
		scnt = 4'h0;
		scroll = 1'b0;
		{cyc, stb, we, adr, sel, wdat} = '0;
		cycles = 0;
		miscompares = 0;
		cmp_count = 0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		cfg_is(CFG_DEF);
		wb(1'b0, 4'hC, 4'hF, 32'h0);
		check(rd, 32'h0, "unmapped");
		wb(1'b1, ADR_CONFIG, 4'h2, 32'h0000_6000);
		cfg_is({17'h0, SPAN_MAX, 8'h00});
		wb(1'b1, ADR_CONFIG, 4'h2, 32'h0000_0200);
		cfg_is({17'h0, SPAN_MIN, 8'h00});
		wb(1'b1, ADR_CONFIG, 4'h3, CFG_DEF);
		$display("test registers done");
		i_magnet_operator.hold(1'b1, HLD);
		check({31'h0, prog}, 32'h0, "short hold");
		fault <= 1'b1;
		i_magnet_operator.hold(1'b1, LONG);
		fault <= 1'b0;
		check({31'h0, prog}, 32'h1, "entry");
		item_is(IT_STATUS);
		i_magnet_operator.arrow(1'b1, OPEN);
		check({28'h0, disp.msg}, {28'h0, MSG_STATUS}, "status");
		repeat (16 * 17) @(posedge clk_i);
		item_is(IT_STATUS);
		i_magnet_operator.arrow(1'b0, 0);
		item_is(IT_BUS_ADDR);
		i_magnet_operator.arrow(1'b1, 0);
		item_is(IT_STATUS);
		i_magnet_operator.arrow(1'b1, 0);
		item_is(IT_GAS_TYPE);
		$display("test entry and navigation done");
		i_magnet_operator.arrow(1'b1, OPEN);
		i_magnet_operator.hold(1'b0, 8);
		i_magnet_operator.hold(1'b0, LONG);
		repeat (20) @(posedge clk_i);
		i_magnet_operator.hold(1'b1, 8);
		i_magnet_operator.hold(1'b0, 8);
		i_magnet_operator.hold(1'b1, LONG);
		cfg_is({17'h0, SPAN_DEFAULT, 4'h0, 3'h2, GAS_VOLUME_FRACTION});
		i_magnet_operator.arrow(1'b1, 0);
		item_is(IT_SPAN);
		i_magnet_operator.arrow(1'b1, OPEN);
		for (int i = 0; i < 3; i++) begin
			i_magnet_operator.hold(1'b0, 8);
		end
		i_magnet_operator.hold(1'b1, 8);
		i_magnet_operator.hold(1'b1, LONG);
		cfg_is({17'h0, SPAN_DEFAULT - 7'h2, 4'h0, 3'h2, GAS_VOLUME_FRACTION});
		$display("test settings done");
		i_magnet_operator.arrow(1'b1, 0);
		i_magnet_operator.arrow(1'b1, 0);
		item_is(IT_BUMP);
		gas <= 16'h1234;
		i_magnet_operator.arrow(1'b1, OPEN);
		check({15'h0, bump, reading}, 32'h0001_1234, "bump on");
		i_magnet_operator.hold(1'b1, 8);
		repeat (20) @(posedge clk_i);
		check({31'h0, bump}, 32'h0, "bump swipe");
		i_magnet_operator.arrow(1'b0, OPEN);
		check({31'h0, bump}, 32'h1, "bump again");
		repeat (BMP + 40) @(posedge clk_i);
		check({31'h0, bump}, 32'h0, "bump time");
		$display("test bump done");
		i_magnet_operator.arrow(1'b1, 0);
		item_is(IT_RESTORE);
		i_magnet_operator.hold(1'b1, RST + DEB + 10);
		cfg_is(CFG_DEF);
		wb(1'b1, ADR_CONFIG, 4'h3, 32'h0000_2805);
		i_magnet_operator.hold(1'b0, RST + DEB + 10);
		cfg_is(32'h0000_2805);
		repeat (TMO + 80) @(posedge clk_i);
		check({31'h0, prog}, 32'h0, "timeout");
		$display("test restore and timeout done");
		test_done();
	end
endmodule

// File: test/magnet_menu_chk.sv
// port checks of the magnet menu controller
`timescale 1ns/1ps
module magnet_menu_chk
	import menu_pkg::*;
#(
	parameter int unsigned DEB_CYC = 4,
	parameter int unsigned TMO_CYC = 100
) (
	// clock and reset
	input wire logic            clk_i,
	input wire logic            rst_i,
	// inputs
	input wire logic            backward_magnet_switch_i,
	input wire logic            forward_magnet_switch_i,
	input wire logic [15:0]     gas_reading_i,
	input wire logic            cyc_i,
	input wire logic            stb_i,
	// outputs
	input wire menu_pkg::disp_t disp_o,
	input wire logic            program_mode_o,
	input wire logic            bump_active_o,
	input wire logic            defaults_load_o,
	input wire menu_pkg::cfg_t  cfg_o,
	input wire logic [15:0]     reading_o,
	input wire logic            ack_o
);
	logic [31:0] idle_reg;
	logic        quiet;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	////////////////////////////////////////
	// cycles on item text with no magnet
	assign quiet = program_mode_o && disp_o.msg == MSG_ITEM && !backward_magnet_switch_i && !forward_magnet_switch_i;
	always_ff @(posedge clk_i) begin
		if (rst_i || !quiet) begin
			idle_reg <= 32'h0;
		end else begin
			idle_reg <= idle_reg + 32'h1;
		end
	end

	////////////////////////////////////////
	a_reading_delay: assert property (!$past(rst_i) |-> reading_o == $past(gas_reading_i))
		else $error("reading is not the delayed sensor value");
	a_span_bounds: assert property (cfg_o.span >= SPAN_MIN && cfg_o.span <= SPAN_MAX)
		else $error("span level out of limits");
	a_entry_item: assert property ($rose(program_mode_o) |-> disp_o.msg == MSG_ITEM && disp_o.value == 8'h00)
		else $error("entry not on status item");
	a_prompt_first: assert property ($rose(program_mode_o) |-> $past(disp_o.msg) == MSG_PROMPT)
		else $error("entry without prompt");
	a_idle_exit: assert property (idle_reg <= TMO_CYC + DEB_CYC + 8)
		else $error("idle item text kept too long");
	a_restore_values: assert property (defaults_load_o |-> ##[0:1] (cfg_o.span == SPAN_DEFAULT
		&& cfg_o.range == RANGE_DEFAULT && cfg_o.gas_type == GAS_TYPE_DEFAULT))
		else $error("defaults not loaded");
	a_restore_pulse: assert property (defaults_load_o |=> !defaults_load_o)
		else $error("defaults load longer than one cycle");
	a_bump_inside: assert property (bump_active_o |-> program_mode_o)
		else $error("bump test outside program mode");
	a_ack_pulse: assert property (ack_o |-> $past(cyc_i && stb_i && !ack_o) ##1 !ack_o)
		else $error("ack without request or too long");

	c_entry: cover property ($rose(program_mode_o));
	c_fault_list: cover property (disp_o.msg == MSG_FAULT);
	c_bump: cover property ($rose(bump_active_o));
	c_restore: cover property (defaults_load_o);
endmodule

bind magnet_menu magnet_menu_chk #(.DEB_CYC(DEB_CYC), .TMO_CYC(TMO_CYC)) i_magnet_menu_chk (
	.clk_i, .rst_i, .backward_magnet_switch_i, .forward_magnet_switch_i, .gas_reading_i, .cyc_i, .stb_i,
	.disp_o, .program_mode_o, .bump_active_o, .defaults_load_o, .cfg_o, .reading_o, .ack_o
);

// File: test/magnet_operator.sv
// operator holding a magnet over the two switches
`timescale 1ns/1ps
module magnet_operator
	import menu_pkg::*;
#(
	parameter int SETTLE = 8
) (
	// clock
	input  wire logic            clk_i,
	// display watched
	input  wire menu_pkg::disp_t disp_i,
	// magnet
	output logic                 back_o,
	output logic                 fwd_o
);
	initial begin
		back_o = 1'b0;
		fwd_o = 1'b0;
	end

	task automatic put(input logic f, input logic on);
		if (f) begin
			fwd_o <= on;
		end else begin
			back_o <= on;
		end
	endtask

	// fixed hold, then magnet away long enough to settle
	task automatic hold(input logic f, input int n);
		@(posedge clk_i);
		put(f, 1'b1);
		repeat (n) @(posedge clk_i);
		put(f, 1'b0);
		repeat (SETTLE) @(posedge clk_i);
	endtask

	// hold until the arrow shows, then extra cycles
	task automatic arrow(input logic f, input int extra);
		int n;
		n = 0;
		@(posedge clk_i);
		put(f, 1'b1);
		do begin
			@(posedge clk_i);
			n++;
		end while (disp_i.arrow_fwd !== 1'b1 && disp_i.arrow_back !== 1'b1 && n < 400);
		repeat (extra) @(posedge clk_i);
		put(f, 1'b0);
		repeat (SETTLE) @(posedge clk_i);
	endtask
endmodule
